/* File: verilog/cstat_pkg.sv */
`default_nettype none
package cstat_pkg;
    // register numbers
    localparam logic [15:0] UNIT_STATUS_REG = 16'h007f;
    localparam logic [15:0] SLAVE_STATUS_BASE = 16'h0100;
    // unit status word bit positions
    localparam int BIT_CFG_ERR = 0;
    localparam int BIT_NO_COMM = 1;
    localparam int BIT_NVM_BLANK = 2;
    localparam int BIT_NVM_FAIL = 3;
    localparam int BIT_SLV_MALF = 4;
    localparam int BIT_BURST_FAIL = 5;
    localparam int BIT_SW_WDOG = 6;
    localparam int BIT_HW_WDOG = 7;
    localparam int BIT_AO_FIXED = 8;
    localparam int BIT_SW_FAIL = 10;
    localparam int BIT_OFFLINE = 11;
    localparam int BIT_PART_COMM = 12;
    localparam int BIT_CSUM_ERR = 15;
    // slave status byte layout
    localparam int BIT_COMM_ERR = 7;
    localparam int BIT_FLD_MALF = 7;
    localparam int BIT_AO_CUR_FIXED = 3;
    localparam logic [15:0] SLAVE_STATUS_RESET = 16'h0000;
    // blink half period: 250 ms at 100 MHz
    localparam int BLINK_MS = 250;
    localparam int CLK_MHZ = 100;
    localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
    // indicator colours
    typedef enum logic [1:0] {
        CSTAT_LED_OFF = 2'b00,
        CSTAT_LED_GREEN = 2'b01,
        CSTAT_LED_RED = 2'b10
    } cstat_led_e;
endpackage
`default_nettype wire

/* File: verilog/cstat_top.sv */
`timescale 1ns/10ps
`default_nettype none
module cstat_top
    import cstat_pkg::*;
#(
    parameter int NUM_SLAVES = 16,
    parameter int BLINK_COUNT = BLINK_CYCLES,
    parameter bit PART_FAIL_SUPPORT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // unit fault inputs
    input wire logic cfg_data_err,
    input wire logic nvm_blank,
    input wire logic nvm_fail,
    input wire logic burst_fail,
    input wire logic sw_watchdog,
    input wire logic hardware_watchdog,
    input wire logic sw_fail,
    input wire logic cfg_csum_err,
    input wire logic burst_mismatch,
    input wire logic input_present,
    // slave messages
    input wire logic msg_valid,
    input wire logic [$clog2(NUM_SLAVES)-1:0] msg_slave,
    input wire logic [15:0] msg_status,
    input wire logic [NUM_SLAVES-1:0] slave_online,
    // register read port
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // indicators
    output logic [1:0] input_indicator,
    output logic [1:0] readiness_indicator
);
    // refuse sizes the decode and timebase cannot serve
    if (NUM_SLAVES < 2 || NUM_SLAVES > 256) begin : g_bad_slaves
        $error("NUM_SLAVES out of range");
    end
    if (BLINK_COUNT < 1) begin : g_bad_blink
        $error("BLINK_COUNT must be positive");
    end

    localparam int SW = $clog2(NUM_SLAVES);

    // per-slave status store
    logic [15:0] slave_status_pair [NUM_SLAVES];
    logic [NUM_SLAVES-1:0] comm_bad;
    logic [NUM_SLAVES-1:0] malf;
    logic [NUM_SLAVES-1:0] ao_fixed;

    // per-slave decode of the stored pair
    genvar g;
    generate
        for (g = 0; g < NUM_SLAVES; g++) begin : g_slv
            wire logic is_err = slave_status_pair[g][8+BIT_COMM_ERR];
            assign comm_bad[g] = is_err && (slave_status_pair[g][14:9] != 6'h00);
            // field flags ignored under a communication error
            assign malf[g] = !is_err && slave_status_pair[g][BIT_FLD_MALF];
            assign ao_fixed[g] = !is_err && slave_status_pair[g][BIT_AO_CUR_FIXED];
        end
    endgenerate

    // slave status store, one process so each word has a single driver
    always_ff @(posedge clk) begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
            if (!rst_n) begin
                slave_status_pair[s] <= SLAVE_STATUS_RESET;
            end else if (clk_en && msg_valid && msg_slave == SW'(s)) begin
                slave_status_pair[s] <= msg_status;
            end
        end
    end

    // summary conditions
    wire logic any_bad = |comm_bad;
    wire logic all_bad = &comm_bad;
    wire logic partial_fail = PART_FAIL_SUPPORT && any_bad && !all_bad;
    wire logic no_comm = all_bad;
    wire logic offline = ~&slave_online;
    wire logic internal_fault = cfg_data_err | nvm_fail | sw_watchdog | hardware_watchdog | sw_fail | cfg_csum_err;

    // unit status word assembly; bits 9, 13, 14 held zero
    logic [15:0] next_unit_status;
    always_comb begin
        next_unit_status = 16'h0000;
        next_unit_status[BIT_CFG_ERR] = cfg_data_err;
        next_unit_status[BIT_NO_COMM] = no_comm;
        next_unit_status[BIT_NVM_BLANK] = nvm_blank;
        next_unit_status[BIT_NVM_FAIL] = nvm_fail;
        next_unit_status[BIT_SLV_MALF] = |malf;
        next_unit_status[BIT_BURST_FAIL] = burst_fail;
        next_unit_status[BIT_SW_WDOG] = sw_watchdog;
        next_unit_status[BIT_HW_WDOG] = hardware_watchdog;
        next_unit_status[BIT_AO_FIXED] = |ao_fixed;
        next_unit_status[BIT_SW_FAIL] = sw_fail;
        next_unit_status[BIT_OFFLINE] = offline;
        next_unit_status[BIT_PART_COMM] = partial_fail;
        next_unit_status[BIT_CSUM_ERR] = cfg_csum_err;
    end

    logic [15:0] unit_status_word;
    always_ff @(posedge clk) begin
        if (!rst_n) unit_status_word <= 16'h0000;
        else if (clk_en) unit_status_word <= next_unit_status;
    end

    // read decode
    wire logic hit_unit = rd_addr == UNIT_STATUS_REG;
    wire logic hit_slave = rd_addr >= SLAVE_STATUS_BASE && rd_addr < SLAVE_STATUS_BASE + 16'(NUM_SLAVES);
    wire logic [15:0] slave_off = rd_addr - SLAVE_STATUS_BASE;
    wire logic [15:0] next_rd_data = hit_unit ? unit_status_word :
        hit_slave ? slave_status_pair[slave_off[SW-1:0]] : 16'h0000;

    // read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= rd_en;
            if (rd_en) rd_data <= next_rd_data;
        end
    end

    // blink timebase
    logic [31:0] blink_cnt;
    logic blink_phase;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blink_cnt <= 32'h0000_0000;
            blink_phase <= 1'b0;
        end else if (clk_en) begin
            if (blink_cnt >= 32'(BLINK_COUNT - 1)) begin
                blink_cnt <= 32'h0000_0000;
                blink_phase <= !blink_phase;
            end else begin
                blink_cnt <= blink_cnt + 32'h0000_0001;
            end
        end
    end

    // indicator selection
    // burst mismatch blinks on every revision, partial failure only when supported
    wire logic blink_req = partial_fail || burst_mismatch;
    wire logic [1:0] next_input_ind = !input_present ? CSTAT_LED_RED :
        blink_req ? (blink_phase ? CSTAT_LED_RED : CSTAT_LED_GREEN) : CSTAT_LED_GREEN;
    wire logic [1:0] next_ready_ind = internal_fault ? CSTAT_LED_RED : CSTAT_LED_GREEN;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_indicator <= CSTAT_LED_OFF;
            readiness_indicator <= CSTAT_LED_OFF;
        end else if (clk_en) begin
            input_indicator <= next_input_ind;
            readiness_indicator <= next_ready_ind;
        end
    end

    // checks
    unit_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
        (unit_status_word[9] | unit_status_word[13] | unit_status_word[14]) == 1'b0)
        else $error("reserved status bits set");
    unit_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && rd_en && hit_unit |=> rd_valid && rd_data == $past(unit_status_word))
        else $error("unit status read wrong");
    slave_refresh_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && msg_valid |=> slave_status_pair[$past(msg_slave)] == $past(msg_status))
        else $error("slave status not refreshed");
    partial_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && partial_fail |=> unit_status_word[BIT_PART_COMM])
        else $error("partial failure not flagged");
    err_masks_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && (&comm_bad) |=> !unit_status_word[BIT_SLV_MALF] && !unit_status_word[BIT_AO_FIXED])
        else $error("field flags used under comm error");
    input_red_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !input_present |=> input_indicator == CSTAT_LED_RED)
        else $error("input indicator not red");
    readiness_indicator_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && internal_fault |=> readiness_indicator == CSTAT_LED_RED)
        else $error("readiness not red on fault");
    hw_wdog_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && hardware_watchdog |=> unit_status_word[BIT_HW_WDOG])
        else $error("watchdog bit missing");
    rd_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !rd_en |=> !rd_valid)
        else $error("read valid without request");
    no_comm_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && (&comm_bad) |=> unit_status_word[BIT_NO_COMM])
        else $error("no communication bit missing");
    offline_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !(&slave_online) |=> unit_status_word[BIT_OFFLINE])
        else $error("offline bit missing");
    comm_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && msg_valid && msg_status[15] && (msg_status[14:9] != 6'h00) |=> comm_bad[$past(msg_slave)])
        else $error("comm error flags not decoded");
    resp_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && msg_valid && !msg_status[15] |=> !comm_bad[$past(msg_slave)])
        else $error("response code taken as comm error");
    input_green_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && input_present && !blink_req |=> input_indicator == CSTAT_LED_GREEN)
        else $error("input indicator not green");
    blink_led_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && input_present && blink_req |=>
        input_indicator == ($past(blink_phase) ? CSTAT_LED_RED : CSTAT_LED_GREEN))
        else $error("input indicator not blinking");
    ready_green_a: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && !internal_fault |=> readiness_indicator == CSTAT_LED_GREEN)
        else $error("readiness not green when ready");
endmodule // cstat_top
`default_nettype wire

/* File: sim/cstat_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cstat_slave_model (
    // clock
    input wire logic clk,
    // message lines toward the unit
    output logic msg_valid,
    output logic [3:0] msg_slave,
    output logic [15:0] msg_status
);
    // idle lines at start
    initial begin
        msg_valid = 1'b0;
        msg_slave = 4'h0;
        msg_status = 16'h0000;
    end
    // one reply of two status bytes, data scrambled once released
    task automatic send(input logic [3:0] s, input logic [15:0] st);
        @(negedge clk);
        msg_valid = 1'b1;
        msg_slave = s;
        msg_status = st;
        @(negedge clk);
        msg_valid = 1'b0;
        msg_status = ~st;
    endtask
endmodule // cstat_slave_model
`default_nettype wire

/* File: sim/converter_status_reporting_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module converter_status_reporting_bench;
    import cstat_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, bm = 1'b0, inp = 1'b1, en = 1'b1, rd_valid, mv;
    logic [7:0] flt = 8'h00;
    logic [15:0] onl = 16'hffff, rd_addr = 16'h0000, rd_data, ms, got;
    logic [3:0] msl;
    logic [1:0] in_led, rdy_led;
    int n_fail = 0, n_tests = 0, i;
    int pos[8] = '{BIT_CFG_ERR, BIT_NVM_BLANK, BIT_NVM_FAIL, BIT_BURST_FAIL, BIT_SW_WDOG, BIT_HW_WDOG,
        BIT_SW_FAIL, BIT_CSUM_ERR};
    // clock and units under test
    always #5 clk = ~clk;
    cstat_slave_model sm (.clk(clk), .msg_valid(mv), .msg_slave(msl), .msg_status(ms));
    cstat_top #(.BLINK_COUNT(4)) dut (.clk(clk), .rst_n(rst_n), .clk_en(en), .cfg_data_err(flt[0]),
        .nvm_blank(flt[1]), .nvm_fail(flt[2]), .burst_fail(flt[3]), .sw_watchdog(flt[4]),
        .hardware_watchdog(flt[5]), .sw_fail(flt[6]), .cfg_csum_err(flt[7]), .burst_mismatch(bm),
        .input_present(inp), .msg_valid(mv), .msg_slave(msl), .msg_status(ms), .slave_online(onl),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .input_indicator(in_led), .readiness_indicator(rdy_led));
    // shared helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [15:0] a);
        int k;
        repeat (4) @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        for (k = 0; k < 4 && rd_valid !== 1'b1; k++) @(negedge clk);
        if (rd_valid !== 1'b1) begin
            n_fail++;
            finish_test();
        end
        got = rd_data;
    endtask
    task automatic blink;
        logic g, r;
        g = 1'b0;
        r = 1'b0;
        repeat (40) begin
            @(negedge clk);
            g |= (in_led === CSTAT_LED_GREEN);
            r |= (in_led === CSTAT_LED_RED);
        end
        check({14'h0000, g, r}, 16'h0003);
    endtask
    // scenarios
    task automatic t_reset;
        repeat (20) @(negedge clk);
        check({12'h000, in_led, rdy_led}, 16'h0000);
        rst_n = 1'b1;
        rd(UNIT_STATUS_REG);
        check(got, 16'h0000);
        check({14'h0000, rdy_led}, {14'h0000, CSTAT_LED_GREEN});
        check({14'h0000, in_led}, {14'h0000, CSTAT_LED_GREEN});
        $display("reset test done");
    endtask
    task automatic t_faults;
        for (i = 0; i < 8; i++) begin
            flt = 8'h01 << i;
            rd(UNIT_STATUS_REG);
            check(got, 16'h0001 << pos[i]);
            if (i == 5) check({14'h0000, rdy_led}, {14'h0000, CSTAT_LED_RED});
        end
        flt = 8'hff;
        rd(UNIT_STATUS_REG);
        check(got, 16'h84ed);
        flt = 8'h00;
        rd(16'h0080);
        check(got, 16'h0000);
        $display("fault test done");
    endtask
    task automatic t_slaves;
        sm.send(4'h3, 16'h0088);
        rd(UNIT_STATUS_REG);
        check(got, 16'h0110);
        rd(SLAVE_STATUS_BASE + 16'h0003);
        check(got, 16'h0088);
        sm.send(4'h3, 16'h2000);
        rd(SLAVE_STATUS_BASE + 16'h0003);
        check(got, 16'h2000);
        sm.send(4'h5, 16'h8480);
        rd(UNIT_STATUS_REG);
        check(got, 16'h1000);
        blink();
        for (i = 0; i < 16; i++) sm.send(i[3:0], 16'h8200);
        rd(UNIT_STATUS_REG);
        check(got, 16'h0002);
        for (i = 0; i < 16; i++) sm.send(i[3:0], 16'h0000);
        onl = 16'hfffb;
        rd(UNIT_STATUS_REG);
        check(got, 16'h0800);
        onl = 16'hffff;
        $display("slave test done");
    endtask
    task automatic t_leds;
        inp = 1'b0;
        repeat (4) @(negedge clk);
        check({14'h0000, in_led}, {14'h0000, CSTAT_LED_RED});
        inp = 1'b1;
        bm = 1'b1;
        blink();
        $display("indicator test done");
    endtask
    task automatic t_freeze;
        en = 1'b0;
        flt = 8'h20;
        repeat (4) @(negedge clk);
        check({14'h0000, rdy_led}, {14'h0000, CSTAT_LED_GREEN});
        en = 1'b1;
        repeat (2) @(negedge clk);
        check({14'h0000, rdy_led}, {14'h0000, CSTAT_LED_RED});
        flt = 8'h00;
        sm.send(4'h5, 16'h0088);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check({12'h000, in_led, rdy_led}, 16'h0000);
        rst_n = 1'b1;
        rd(SLAVE_STATUS_BASE + 16'h0005);
        check(got, 16'h0000);
        $display("freeze and reset test done");
    endtask
    // main sequence
    initial begin
        t_reset();
        t_faults();
        t_slaves();
        t_leds();
        t_freeze();
        finish_test();
    end
endmodule // converter_status_reporting_bench
`default_nettype wire
